/* leading_edge_input_handshake.sv */
`timescale 1ns/1ps
`default_nettype none
module leading_edge_input_handshake #(
    parameter int WIDTH = handshake_pkg::DATA_WIDTH,
    parameter int DEPTH = handshake_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic arm,
    input wire logic [handshake_pkg::CNT_W-1:0] ack_delay,
    input wire logic req_edge_latch,
    input wire logic req,
    input wire logic [WIDTH-1:0] din,
    output logic ack,
    output logic armed,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [handshake_pkg::TCNT_W-1:0] xfer_count
);
    typedef struct packed {
        logic req_m;
        logic req_s;
        logic req_d;
        logic [WIDTH-1:0] din_m;
        logic [WIDTH-1:0] din_s;
        handshake_pkg::hs_state_t state;
        logic [handshake_pkg::CNT_W-1:0] cnt;
        logic [handshake_pkg::CNT_W-1:0] gap;
        logic ack;
        logic first;
        logic got;
        logic wr_valid;
        logic [WIDTH-1:0] wr_data;
        logic [handshake_pkg::TCNT_W-1:0] xfers;
        logic latch_mode;
    } hs_st_t;

    localparam logic [handshake_pkg::CNT_W-1:0] ACK_W =
        handshake_pkg::CNT_W'(handshake_pkg::ACK_WIDTH_CYC);
    localparam logic [handshake_pkg::CNT_W-1:0] PER_MIN =
        handshake_pkg::CNT_W'(handshake_pkg::ACK_PERIOD_MIN_CYC);
    localparam logic [handshake_pkg::CNT_W-1:0] SETUP =
        handshake_pkg::CNT_W'(handshake_pkg::DATA_SETUP_CYC);

    hs_st_t st;
    hs_st_t next_st;
    logic fifo_ready;
    logic fifo_valid;
    logic [WIDTH-1:0] fifo_data;
    logic out_take;
    logic req_rise;
    logic req_fall;

    assign req_rise = st.req_s && !st.req_d;
    assign req_fall = !st.req_s && st.req_d;
    assign out_take = !out_valid || out_ready;

    always_comb begin
        next_st = st;
        next_st.req_m = req;
        next_st.req_s = st.req_m;
        next_st.req_d = st.req_s;
        next_st.din_m = din;
        next_st.din_s = st.din_m;
        next_st.wr_valid = 1'b0;
        if (st.gap != '0) begin
            next_st.gap = st.gap - 1'b1;
        end
        // latching mode follows setting only while idle
        if (st.state == handshake_pkg::ST_IDLE) begin
            next_st.latch_mode = req_edge_latch;
        end
        case (st.state)
            handshake_pkg::ST_IDLE: begin
                next_st.ack = 1'b0;
                if (arm) begin
                    next_st.state = handshake_pkg::ST_WAIT_REQ;
                    next_st.first = 1'b1;
                end
            end
            handshake_pkg::ST_WAIT_REQ: begin
                if (!arm) begin
                    next_st.state = handshake_pkg::ST_IDLE;
                end else if (st.req_s) begin
                    next_st.state = handshake_pkg::ST_DELAY;
                    next_st.cnt = ack_delay + SETUP;
                end
            end
            handshake_pkg::ST_DELAY: begin
                if (st.cnt != '0) begin
                    next_st.cnt = st.cnt - 1'b1;
                end else if (fifo_ready && st.gap == '0) begin
                    // acknowledge when ready and period elapsed
                    next_st.state = handshake_pkg::ST_ACK;
                    next_st.ack = 1'b1;
                    next_st.got = 1'b0;
                    next_st.cnt = ACK_W - 1'b1;
                    next_st.gap = PER_MIN - 1'b1 + ack_delay;
                end
            end
            handshake_pkg::ST_ACK: begin
                if (st.cnt != '0) begin
                    next_st.cnt = st.cnt - 1'b1;
                end
                // word may arrive while acknowledge high
                if (req_rise && !st.got) begin
                    next_st.wr_valid = 1'b1;
                    next_st.wr_data = st.din_s;
                    next_st.xfers = st.xfers + 1'b1;
                    next_st.first = 1'b0;
                    next_st.got = 1'b1;
                end
                if (st.cnt == '0 && !st.req_s) begin
                    next_st.ack = 1'b0;
                    next_st.got = 1'b0;
                    if (st.got) begin
                        next_st.state = handshake_pkg::ST_DELAY;
                        next_st.cnt = ack_delay + SETUP;
                    end else begin
                        next_st.state = handshake_pkg::ST_GAP;
                    end
                end
            end
            handshake_pkg::ST_GAP: begin
                // capture on request rise after acknowledge
                if (!arm) begin
                    next_st.state = handshake_pkg::ST_IDLE;
                end else if (req_rise) begin
                    next_st.wr_valid = 1'b1;
                    next_st.wr_data = st.din_s;
                    next_st.xfers = st.xfers + 1'b1;
                    next_st.first = 1'b0;
                    next_st.state = handshake_pkg::ST_DELAY;
                    next_st.cnt = ack_delay + SETUP;
                end
            end
            default: begin
                next_st.state = handshake_pkg::ST_IDLE;
                next_st.ack = 1'b0;
            end
        endcase
        if (req_fall && st.latch_mode) begin
            next_st.first = st.first;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{state: handshake_pkg::ST_IDLE, xfers: handshake_pkg::TCNT_RESET,
                cnt: handshake_pkg::CNT_RESET, gap: handshake_pkg::CNT_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(st.wr_valid),
        .in_ready(fifo_ready),
        .in_data(st.wr_data),
        .out_valid(fifo_valid),
        .out_ready(out_take),
        .out_data(fifo_data)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid <= 1'b0;
            out_data <= '0;
            ack <= 1'b0;
            armed <= 1'b0;
            xfer_count <= handshake_pkg::TCNT_RESET;
        end else begin
            ack <= next_st.ack;
            armed <= (next_st.state != handshake_pkg::ST_IDLE);
            xfer_count <= next_st.xfers;
            if (out_take) begin
                out_valid <= fifo_valid;
                out_data <= fifo_data;
            end
        end
    end

    AST_IDLE_ACK_LOW: assert property (@(posedge clk) disable iff (!rst_b)
        st.state == handshake_pkg::ST_IDLE |=> !ack)
        else $error("ack high while idle");
    AST_ACK_STRETCH: assert property (@(posedge clk) disable iff (!rst_b)
        st.state == handshake_pkg::ST_ACK && st.req_s |=> st.ack)
        else $error("ack dropped with request high");
    AST_ACK_WIDTH: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(st.ack) |-> st.ack [*5])
        else $error("ack pulse too short");
    AST_ONE_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
        st.wr_valid |-> st.xfers == $past(st.xfers) + 1'b1)
        else $error("transfer count mismatch");
    AST_CAPTURE_EDGE: assert property (@(posedge clk) disable iff (!rst_b)
        st.wr_valid |-> $past(req_rise) && ($past(st.state) == handshake_pkg::ST_GAP
            || $past(st.state) == handshake_pkg::ST_ACK))
        else $error("capture without request edge");
    logic [handshake_pkg::CNT_W-1:0] ack_age;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_age <= '1;
        end else if (next_st.ack && !st.ack) begin
            ack_age <= handshake_pkg::CNT_RESET;
        end else if (ack_age != '1) begin
            ack_age <= ack_age + 1'b1;
        end
    end
    AST_ACK_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(st.ack) |-> $past(ack_age) >= PER_MIN - 1'b1)
        else $error("ack interval too short");
    AST_ARM_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
        st.state == handshake_pkg::ST_IDLE && !arm |=> st.state == handshake_pkg::ST_IDLE)
        else $error("left idle without arm");
    AST_SETUP: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(st.ack) |-> $past(st.state, 3) == handshake_pkg::ST_DELAY)
        else $error("ack without data setup");
endmodule : leading_edge_input_handshake
`default_nettype wire

/* handshake_pkg.sv */
package handshake_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // acknowledge-to-acknowledge interval bounds, ns
    localparam int ACK_PERIOD_MIN_NS = 225;
    localparam int ACK_PERIOD_MAX_NS = 275;
    localparam int ACK_PERIOD_MIN_CYC = (ACK_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_PERIOD_MAX_CYC = ACK_PERIOD_MAX_NS / CLK_PERIOD_NS;
    // minimum acknowledge pulse width, ns (stretched while request high)
    localparam int ACK_WIDTH_NS = 50;
    localparam int ACK_WIDTH_CYC = (ACK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // output data valid before acknowledge, ns
    localparam int DATA_SETUP_NS = 25;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_WIDTH = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 16;
    localparam int TCNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [TCNT_W-1:0] TCNT_RESET = 32'h0000_0000;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT_REQ = 5'b00010,
        ST_DELAY = 5'b00100,
        ST_ACK = 5'b01000,
        ST_GAP = 5'b10000
    } hs_state_t;

    typedef struct packed {
        logic req;
        logic [DATA_WIDTH-1:0] data;
    } link_in_t;

    typedef struct packed {
        logic valid;
        logic [DATA_WIDTH-1:0] data;
    } word_t;
endpackage : handshake_pkg

/* word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_st_t;
    fifo_st_t st;
    fifo_st_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic do_wr;
    logic do_rd;

    assign in_ready = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data = mem[st.rp];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (do_wr) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (do_rd) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule : word_fifo
`default_nettype wire

/* peripheral_model.sv */
`timescale 1ns/1ps
`default_nettype none
module peripheral_model (
    input wire logic clk,
    input wire logic ack,
    output logic req,
    output logic [handshake_pkg::DATA_WIDTH-1:0] din
);
    logic seen = 1'b0;
    initial begin
        req = 1'b0;
        din = '0;
    end
    always @(posedge ack) seen = 1'b1;
    task automatic start(input bit hold);
        int n;
        n = 0;
        seen = 1'b0;
        req = 1'b1;
        repeat (3) @(posedge clk);
        while (hold && !seen && n < 200) begin
            @(posedge clk);
            n++;
        end
        #1 req = 1'b0;
    endtask : start
    task automatic send(input logic [handshake_pkg::DATA_WIDTH-1:0] d, input int slow,
            output bit ok);
        int n;
        n = 0;
        while (!seen && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        ok = seen;
        seen = 1'b0;
        repeat (slow) begin
            @(posedge clk);
            #1;
        end
        din = d;
        @(posedge clk);
        #1 req = 1'b1;
        repeat (2 + slow) @(posedge clk);
        #1 req = 1'b0;
        repeat (3) @(posedge clk);
        #1 din = ~d;
    endtask : send
endmodule : peripheral_model
`default_nettype wire

/* leading_edge_input_handshake_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module leading_edge_input_handshake_tb;
    localparam int W = handshake_pkg::DATA_WIDTH;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic arm = 1'b0;
    logic [handshake_pkg::CNT_W-1:0] ack_delay = '0;
    logic req_edge_latch = 1'b0;
    logic out_ready = 1'b0;
    logic hold_rdy = 1'b0;
    logic req, ack, armed, out_valid, pa;
    logic [W-1:0] din, out_data;
    logic [handshake_pkg::TCNT_W-1:0] xfer_count;
    int n_mismatch = 0, tests_run = 0, cyc = 0, last = -1, rises = 0, wide = 0, sent = 0, n;
    logic [W-1:0] exp_q[$];
    bit ok;
    always #5 clk = ~clk;
    leading_edge_input_handshake dut_u (.clk(clk), .rst_b(rst_b), .arm(arm),
        .ack_delay(ack_delay), .req_edge_latch(req_edge_latch), .req(req), .din(din),
        .ack(ack), .armed(armed), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .xfer_count(xfer_count));
    peripheral_model per_u (.clk(clk), .ack(ack), .req(req), .din(din));
    task automatic chk_val(input logic [W-1:0] got, input logic [W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        chk_val(W'(got), W'(exp));
    endtask : chk_bit
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : step
    task automatic run(input int k, input int slow);
        logic [W-1:0] d;
        repeat (k) begin
            d = $urandom;
            exp_q.push_back(d);
            sent++;
            per_u.send(d, slow, ok);
            if (!ok) begin
                n_mismatch++;
                wrap_up();
            end
        end
    endtask : run
    always @(posedge clk) out_ready <= hold_rdy ? 1'b0 : 1'($urandom);
    always @(posedge clk) begin
        cyc++;
        if (out_valid === 1'b1 && out_ready === 1'b1)
            chk_val(out_data, exp_q.size() ? exp_q.pop_front() : ~out_data);
        if (ack === 1'b1 && !pa) begin
            rises++;
            if (last >= 0)
                chk_bit(cyc - last >= handshake_pkg::ACK_PERIOD_MIN_CYC + ack_delay, 1'b1);
            last = cyc;
        end
        if (ack === 1'b1) wide++;
        if (ack !== 1'b1 && pa) begin
            chk_bit(wide >= handshake_pkg::ACK_WIDTH_CYC && req === 1'b0, 1'b1);
            wide = 0;
        end
        if (!arm) last = -1;
        pa = (ack === 1'b1);
    end
    initial begin
        void'($urandom(13269));
        req_edge_latch = 1'($urandom);
        step(10);
        rst_b = 1'b1;
        chk_bit(ack, 1'b0);
        chk_bit(armed, 1'b0);
        chk_val(xfer_count, '0);
        $display("test reset done");
        per_u.start(1'b0);
        step(60);
        chk_val(W'(rises), '0);
        arm = 1'b1;
        step(2);
        chk_bit(armed, 1'b1);
        per_u.start(1'b0);
        run(8, 0);
        step(30);
        chk_val(xfer_count, W'(sent));
        arm = 1'b0;
        $display("test prompt pulse done");
        step(10);
        ack_delay = 16'($urandom_range(1, 12));
        arm = 1'b1;
        per_u.start(1'b1);
        run(6, 8);
        step(40);
        chk_val(xfer_count, W'(sent));
        arm = 1'b0;
        $display("test held delayed done");
        step(10);
        ack_delay = '0;
        hold_rdy = 1'b1;
        arm = 1'b1;
        per_u.start(1'b0);
        fork
            run(24, 0);
        join_none
        step(1500);
        n = rises;
        step(200);
        chk_val(W'(rises), W'(n));
        chk_bit(out_valid, 1'b1);
        hold_rdy = 1'b0;
        wait fork;
        for (int i = 0; i < 800 && exp_q.size() > 0; i++) step(1);
        chk_val(W'(exp_q.size()), '0);
        chk_val(xfer_count, W'(sent));
        $display("test fifo stall done");
        wrap_up();
    end
endmodule : leading_edge_input_handshake_tb
`default_nettype wire
